// >>> hdl/agt_pkg.sv
// Shared constants and types for the negotiation and training status block
package agt_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_MHZ        = 125;
	localparam int LT_TIMEOUT_US  = 500;
	localparam int LT_TIMEOUT_CYC = LT_TIMEOUT_US * CLK_MHZ;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int LANES  = 4;
	localparam int PAGE_W = 48;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int TAP_W  = 2;
	localparam int FEC_W  = 4;
	localparam int CW_W   = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Received base page and extended page bit positions
	localparam int BP_RSFEC_REQ = 44;
	localparam int BP_KRFEC_REQ = 45;
	localparam int EP_25G_KR1   = 16;
	localparam int EP_25G_CR1   = 17;
	localparam int EP_50G_KR2   = 18;
	localparam int EP_50G_CR2   = 19;
	localparam int EP_FEC_LSB   = 24;
	localparam int FEC_CAP_RS   = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Received control block layout per lane
	localparam int CW_PRESET  = 5;
	localparam int CW_INIT    = 4;
	localparam int CW_KP1_LSB = 2;
	localparam int CW_K0_LSB  = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_AN_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_LT_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_LT_RXCB = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_NP_LO   = 8'h10;
	localparam logic [ADDR_W-1:0] REG_NP_HI   = 8'h14;

	// Control register fields
	localparam int CTRL_TRAIN_LSB   = 0;
	localparam int CTRL_RSFEC_LOCAL = 4;
	localparam int CTRL_CLEAR_ABIL  = 5;
	localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_001F;

	// Status register fields
	localparam int AN_OVERRUN = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Lane training states
	typedef enum logic [3:0] {
		LT_IDLE  = 4'b0001,
		LT_TRAIN = 4'b0010,
		LT_SEND  = 4'b0100,
		LT_FAIL  = 4'b1000
	} agt_lt_state_e;

endpackage

// >>> hdl/agt_lane_trainer.sv
// Training state, frame status and received control bits of one lane
`timescale 1ns/1ns
module agt_lane_trainer #(
	parameter int TIMEOUT_CYC = agt_pkg::LT_TIMEOUT_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic                       enable,
	input  wire logic                       frame_marker,
	input  wire logic                       frame_sync,
	input  wire logic                       local_ready,
	input  wire logic                       partner_ready,
	input  wire logic                       ctrl_valid,
	input  wire logic [agt_pkg::CW_W-1:0]   ctrl_word,
	output logic                            done,
	output logic                            active,
	output logic                            timeout,
	output logic                            frame_start,
	output logic                            locked,
	output logic                            preset,
	output logic                            init,
	output logic [agt_pkg::TAP_W-1:0]       post_tap,
	output logic [agt_pkg::TAP_W-1:0]       main_tap
);
	localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);

	typedef struct packed {
		agt_pkg::agt_lt_state_e     st;
		logic [CNT_W-1:0]           cnt;
		logic                       done;
		logic                       active;
		logic                       timeout;
		logic                       fstart;
		logic                       locked;
		logic                       preset;
		logic                       init;
		logic [agt_pkg::TAP_W-1:0]  post;
		logic [agt_pkg::TAP_W-1:0]  main;
	} agt_lane_s;

	localparam agt_lane_s LANE_RST = '{st: agt_pkg::LT_IDLE, cnt: '0, default: '0};

	agt_lane_s r_q;
	agt_lane_s r_d;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		r_d = r_q;
		unique case (r_q.st)
			agt_pkg::LT_IDLE:
			begin
				r_d.cnt = '0;
				if (enable)
					r_d.st = agt_pkg::LT_TRAIN;
			end
			agt_pkg::LT_TRAIN:
			begin
				if (!enable)
					r_d.st = agt_pkg::LT_IDLE;
				else if (local_ready && partner_ready)
					r_d.st = agt_pkg::LT_SEND;
				else if (r_q.cnt == CNT_W'(TIMEOUT_CYC - 1))
					r_d.st = agt_pkg::LT_FAIL;
				else
					r_d.cnt = r_q.cnt + CNT_W'(1);
			end
			agt_pkg::LT_SEND, agt_pkg::LT_FAIL:
			begin
				if (!enable)
					r_d.st = agt_pkg::LT_IDLE;
			end
		endcase
		r_d.done    = (r_d.st == agt_pkg::LT_SEND);
		r_d.active  = (r_d.st == agt_pkg::LT_TRAIN);
		r_d.timeout = (r_d.st == agt_pkg::LT_FAIL);
		// Frame status only counts once training has begun
		r_d.fstart  = frame_marker && (r_q.st != agt_pkg::LT_IDLE);
		r_d.locked  = frame_sync && (r_q.st != agt_pkg::LT_IDLE);
		if (ctrl_valid)
		begin
			r_d.preset = ctrl_word[agt_pkg::CW_PRESET];
			r_d.init   = ctrl_word[agt_pkg::CW_INIT];
			r_d.post   = ctrl_word[agt_pkg::CW_KP1_LSB +: agt_pkg::TAP_W];
			r_d.main   = ctrl_word[agt_pkg::CW_K0_LSB +: agt_pkg::TAP_W];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			r_q <= LANE_RST;
		else
			r_q <= r_d;
	end

	assign done        = r_q.done;
	assign active      = r_q.active;
	assign timeout     = r_q.timeout;
	assign frame_start = r_q.fstart;
	assign locked      = r_q.locked;
	assign preset      = r_q.preset;
	assign init        = r_q.init;
	assign post_tap    = r_q.post;
	assign main_tap    = r_q.main;

endmodule

// >>> hdl/agt_status.sv
// Negotiation status, next-page handshake and lane training report with APB registers
`timescale 1ns/1ns
module agt_status #(
	parameter int LT_TIMEOUT_CYC = agt_pkg::LT_TIMEOUT_CYC
) (
	input  wire logic                                   clk,
	input  wire logic                                   reset,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [agt_pkg::ADDR_W-1:0]             paddr,
	input  wire logic [agt_pkg::DATA_W-1:0]             pwdata,
	output logic [agt_pkg::DATA_W-1:0]                  prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic                                   rx_base_page_valid,
	input  wire logic [agt_pkg::PAGE_W-1:0]             rx_base_page_word,
	input  wire logic                                   rx_ext_page_valid,
	input  wire logic [agt_pkg::PAGE_W-1:0]             rx_ext_page_word,
	input  wire logic                                   rx_next_page_valid,
	input  wire logic [agt_pkg::PAGE_W-1:0]             rx_next_page_word,
	input  wire logic                                   tx_page_slot,
	input  wire logic                                   local_page_request,
	input  wire logic [agt_pkg::PAGE_W-1:0]             local_page_word_in,
	input  wire logic                                   partner_page_read_ack,
	output logic                                        partner_rsfec_request,
	output logic                                        partner_kr_fec_request,
	output logic                                        partner_negotiation_capable,
	output logic                                        partner_abilities_valid,
	output logic                                        local_page_taken_pulse,
	output logic                                        tx_page_load,
	output logic [agt_pkg::PAGE_W-1:0]                  tx_page_word,
	output logic                                        partner_page_available,
	output logic [agt_pkg::PAGE_W-1:0]                  partner_page_word_out,
	output logic                                        partner_adv_25g_kr1,
	output logic                                        partner_adv_25g_cr1,
	output logic                                        partner_adv_50g_kr2,
	output logic                                        partner_adv_50g_cr2,
	output logic [agt_pkg::FEC_W-1:0]                   partner_ext_fec_caps,
	output logic                                        rsfec_use_enable,
	output logic                                        partner_ext_caps_valid,
	input  wire logic [agt_pkg::LANES-1:0]              lane_frame_marker,
	input  wire logic [agt_pkg::LANES-1:0]              lane_frame_sync,
	input  wire logic [agt_pkg::LANES-1:0]              lane_local_ready,
	input  wire logic [agt_pkg::LANES-1:0]              lane_partner_ready,
	input  wire logic [agt_pkg::LANES-1:0]              lane_ctrl_valid,
	input  wire logic [agt_pkg::LANES*agt_pkg::CW_W-1:0] lane_ctrl_word,
	output logic [agt_pkg::LANES-1:0]                   lane_training_done,
	output logic [agt_pkg::LANES-1:0]                   lane_training_active,
	output logic [agt_pkg::LANES-1:0]                   lane_training_timeout,
	output logic [agt_pkg::LANES-1:0]                   lane_train_frame_start,
	output logic [agt_pkg::LANES-1:0]                   lane_train_frame_locked,
	output logic [agt_pkg::LANES-1:0]                   partner_preset_bit,
	output logic [agt_pkg::LANES-1:0]                   partner_init_bit,
	output logic [agt_pkg::TAP_W-1:0]                   lane0_post_tap_update,
	output logic [agt_pkg::TAP_W-1:0]                   lane0_main_tap_update
);
	localparam int L = agt_pkg::LANES;
	localparam int T = agt_pkg::TAP_W;

	typedef struct packed {
		logic                          pready;
		logic                          pslverr;
		logic [agt_pkg::DATA_W-1:0]    prdata;
		logic [agt_pkg::DATA_W-1:0]    ctrl;
		logic                          abil_valid;
		logic                          rsfec_req;
		logic                          krfec_req;
		logic                          capable;
		logic                          ext_valid;
		logic                          kr1;
		logic                          cr1;
		logic                          kr2;
		logic                          cr2;
		logic [agt_pkg::FEC_W-1:0]     ext_fec;
		logic                          rsfec_use;
		logic                          np_taken;
		logic                          tx_load;
		logic [agt_pkg::PAGE_W-1:0]    tx_word;
		logic                          np_avail;
		logic                          overrun;
		logic [agt_pkg::PAGE_W-1:0]    np_word;
	} agt_top_s;

	localparam agt_top_s TOP_RST = '{ctrl: agt_pkg::CTRL_RST, default: '0};

	agt_top_s r_q;
	agt_top_s r_d;

	logic [L-1:0]   lt_done;
	logic [L-1:0]   lt_active;
	logic [L-1:0]   lt_timeout;
	logic [L-1:0]   lt_fstart;
	logic [L-1:0]   lt_locked;
	logic [L-1:0]   lt_preset;
	logic [L-1:0]   lt_init;
	logic [L*T-1:0] lt_post;
	logic [L*T-1:0] lt_main;

	// Known register offsets answer; all others give an error
	function automatic logic addr_mapped(input logic [agt_pkg::ADDR_W-1:0] a);
		addr_mapped = (a == agt_pkg::REG_CTRL) || (a == agt_pkg::REG_AN_STAT) ||
			(a == agt_pkg::REG_LT_STAT) || (a == agt_pkg::REG_LT_RXCB) ||
			(a == agt_pkg::REG_NP_LO) || (a == agt_pkg::REG_NP_HI);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Lane training units
	genvar gi;
	generate
		for (gi = 0; gi < L; gi++)
		begin : g_lane
			agt_lane_trainer #(
				.TIMEOUT_CYC (LT_TIMEOUT_CYC)
			) u_lane (
				.clk           (clk),
				.reset         (reset),
				.enable        (r_q.ctrl[agt_pkg::CTRL_TRAIN_LSB + gi]),
				.frame_marker  (lane_frame_marker[gi]),
				.frame_sync    (lane_frame_sync[gi]),
				.local_ready   (lane_local_ready[gi]),
				.partner_ready (lane_partner_ready[gi]),
				.ctrl_valid    (lane_ctrl_valid[gi]),
				.ctrl_word     (lane_ctrl_word[gi*agt_pkg::CW_W +: agt_pkg::CW_W]),
				.done          (lt_done[gi]),
				.active        (lt_active[gi]),
				.timeout       (lt_timeout[gi]),
				.frame_start   (lt_fstart[gi]),
				.locked        (lt_locked[gi]),
				.preset        (lt_preset[gi]),
				.init          (lt_init[gi]),
				.post_tap      (lt_post[gi*T +: T]),
				.main_tap      (lt_main[gi*T +: T])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic setup;
		logic wr_acc;
		logic [agt_pkg::DATA_W-1:0] rd;
		setup  = psel && !penable;
		wr_acc = psel && penable && r_q.pready && pwrite;
		rd     = '0;
		r_d          = r_q;
		r_d.pready   = 1'b0;
		r_d.pslverr  = 1'b0;
		r_d.np_taken = 1'b0;
		r_d.tx_load  = 1'b0;

		// APB: answer is prepared in the setup cycle, no wait states
		unique case (paddr)
			agt_pkg::REG_CTRL:    rd = r_q.ctrl;
			agt_pkg::REG_AN_STAT: rd = {16'h0000, r_q.cr2, r_q.kr2, r_q.cr1, r_q.kr1,
				r_q.ext_fec, r_q.capable, r_q.krfec_req, r_q.rsfec_req, r_q.rsfec_use,
				r_q.overrun, r_q.np_avail, r_q.ext_valid, r_q.abil_valid};
			agt_pkg::REG_LT_STAT: rd = {16'h0000, lt_locked, lt_timeout, lt_active, lt_done};
			agt_pkg::REG_LT_RXCB: rd = {8'h00, lt_init, lt_preset, lt_post, lt_main};
			agt_pkg::REG_NP_LO:   rd = r_q.np_word[agt_pkg::DATA_W-1:0];
			agt_pkg::REG_NP_HI:   rd = {16'h0000, r_q.np_word[agt_pkg::PAGE_W-1:agt_pkg::DATA_W]};
			default:              rd = '0;
		endcase
		if (setup)
		begin
			r_d.pready  = 1'b1;
			r_d.pslverr = !addr_mapped(paddr);
			r_d.prdata  = pwrite ? '0 : rd;
		end

		// Register writes take effect at the end of the access cycle
		if (wr_acc && (paddr == agt_pkg::REG_CTRL))
		begin
			r_d.ctrl = pwdata & agt_pkg::CTRL_MASK;
			if (pwdata[agt_pkg::CTRL_CLEAR_ABIL])
			begin
				r_d.abil_valid = 1'b0;
				r_d.ext_valid  = 1'b0;
			end
		end
		if (wr_acc && (paddr == agt_pkg::REG_AN_STAT) && pwdata[agt_pkg::AN_OVERRUN])
			r_d.overrun = 1'b0;

		// Base page: all advertised values load with the valid flag
		if (rx_base_page_valid)
		begin
			r_d.rsfec_req  = rx_base_page_word[agt_pkg::BP_RSFEC_REQ];
			r_d.krfec_req  = rx_base_page_word[agt_pkg::BP_KRFEC_REQ];
			r_d.capable    = 1'b1;
			r_d.abil_valid = 1'b1;
		end

		// Extended page abilities
		if (rx_ext_page_valid)
		begin
			r_d.kr1       = rx_ext_page_word[agt_pkg::EP_25G_KR1];
			r_d.cr1       = rx_ext_page_word[agt_pkg::EP_25G_CR1];
			r_d.kr2       = rx_ext_page_word[agt_pkg::EP_50G_KR2];
			r_d.cr2       = rx_ext_page_word[agt_pkg::EP_50G_CR2];
			r_d.ext_fec   = rx_ext_page_word[agt_pkg::EP_FEC_LSB +: agt_pkg::FEC_W];
			r_d.ext_valid = 1'b1;
		end

		r_d.rsfec_use = r_d.abil_valid && r_q.ctrl[agt_pkg::CTRL_RSFEC_LOCAL] &&
			(r_d.rsfec_req || (r_d.ext_valid && r_d.ext_fec[agt_pkg::FEC_CAP_RS]));

		// Local next page: sampled when the engine has a slot and the host asks
		if (tx_page_slot && local_page_request)
		begin
			r_d.tx_word  = local_page_word_in;
			r_d.tx_load  = 1'b1;
			r_d.np_taken = 1'b1;
		end

		// Partner next page: acknowledge clears, a new page sets and wins
		if (partner_page_read_ack)
			r_d.np_avail = 1'b0;
		if (rx_next_page_valid)
		begin
			// An unread page being replaced is recorded
			if (r_q.np_avail && !partner_page_read_ack)
				r_d.overrun = 1'b1;
			r_d.np_word  = rx_next_page_word;
			r_d.np_avail = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			r_q <= TOP_RST;
		else
			r_q <= r_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata                      = r_q.prdata;
	assign pready                      = r_q.pready;
	assign pslverr                     = r_q.pslverr;
	assign partner_rsfec_request       = r_q.rsfec_req;
	assign partner_kr_fec_request      = r_q.krfec_req;
	assign partner_negotiation_capable = r_q.capable;
	assign partner_abilities_valid     = r_q.abil_valid;
	assign local_page_taken_pulse      = r_q.np_taken;
	assign tx_page_load                = r_q.tx_load;
	assign tx_page_word                = r_q.tx_word;
	assign partner_page_available      = r_q.np_avail;
	assign partner_page_word_out       = r_q.np_word;
	assign partner_adv_25g_kr1         = r_q.kr1;
	assign partner_adv_25g_cr1         = r_q.cr1;
	assign partner_adv_50g_kr2         = r_q.kr2;
	assign partner_adv_50g_cr2         = r_q.cr2;
	assign partner_ext_fec_caps        = r_q.ext_fec;
	assign rsfec_use_enable            = r_q.rsfec_use;
	assign partner_ext_caps_valid      = r_q.ext_valid;
	assign lane_training_done          = lt_done;
	assign lane_training_active        = lt_active;
	assign lane_training_timeout       = lt_timeout;
	assign lane_train_frame_start      = lt_fstart;
	assign lane_train_frame_locked     = lt_locked;
	assign partner_preset_bit          = lt_preset;
	assign partner_init_bit            = lt_init;
	assign lane0_post_tap_update       = lt_post[T-1:0];
	assign lane0_main_tap_update       = lt_main[T-1:0];

endmodule

// >>> testbench/agt_checker.sv
// Port-level timing checks of the status and next-page block
`timescale 1ns/1ns
module agt_checker (
	input wire logic                       clk,
	input wire logic                       reset,
	input wire logic                       tx_page_slot,
	input wire logic                       local_page_request,
	input wire logic [agt_pkg::PAGE_W-1:0] local_page_word_in,
	input wire logic                       local_page_taken_pulse,
	input wire logic [agt_pkg::PAGE_W-1:0] tx_page_word,
	input wire logic                       rx_next_page_valid,
	input wire logic [agt_pkg::PAGE_W-1:0] rx_next_page_word,
	input wire logic                       partner_page_available,
	input wire logic [agt_pkg::PAGE_W-1:0] partner_page_word_out,
	input wire logic                       partner_page_read_ack,
	input wire logic                       rx_base_page_valid,
	input wire logic [agt_pkg::PAGE_W-1:0] rx_base_page_word,
	input wire logic                       partner_rsfec_request,
	input wire logic                       partner_kr_fec_request,
	input wire logic                       partner_negotiation_capable,
	input wire logic                       partner_abilities_valid,
	input wire logic [agt_pkg::LANES-1:0]  lane_frame_marker,
	input wire logic [agt_pkg::LANES-1:0]  lane_train_frame_start,
	input wire logic [agt_pkg::LANES-1:0]  lane_frame_sync,
	input wire logic [agt_pkg::LANES-1:0]  lane_train_frame_locked
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_take;
		tx_page_slot && local_page_request;
	endsequence
	sequence s_pulse;
		local_page_taken_pulse ##1 !local_page_taken_pulse;
	endsequence

	a_take_pulse: assert property (s_take ##1 !(tx_page_slot && local_page_request)
		|-> s_pulse)
		else $error("bad taken pulse");
	a_take_word: assert property (local_page_taken_pulse
		|-> tx_page_word == $past(local_page_word_in))
		else $error("taken word mismatch");
	a_page_set: assert property (rx_next_page_valid
		|=> partner_page_available && partner_page_word_out == $past(rx_next_page_word))
		else $error("page not presented");
	a_page_clear: assert property (partner_page_read_ack && !rx_next_page_valid
		|=> !partner_page_available)
		else $error("available not cleared");
	a_page_hold: assert property (!partner_page_available && !rx_next_page_valid
		|=> !partner_page_available)
		else $error("available without page");
	a_base_flags: assert property (rx_base_page_valid
		|=> partner_abilities_valid && partner_negotiation_capable
		&& partner_rsfec_request == $past(rx_base_page_word[agt_pkg::BP_RSFEC_REQ])
		&& partner_kr_fec_request == $past(rx_base_page_word[agt_pkg::BP_KRFEC_REQ]))
		else $error("base flags wrong");
	a_frame_start: assert property (
		(lane_train_frame_start & ~$past(lane_frame_marker)) == 4'h0)
		else $error("start without marker");
	a_frame_lock: assert property (
		(lane_train_frame_locked & ~$past(lane_frame_sync)) == 4'h0)
		else $error("lock without sync");
endmodule

bind agt_status agt_checker chk_u (.*);

// >>> testbench/agt_host_model.sv
// Host model: offers local next pages and acknowledges partner pages
`timescale 1ns/1ns
module agt_host_model #(
	parameter int PAGES = 5
) (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic                       stall,
	input  wire logic                       local_page_taken_pulse,
	input  wire logic                       partner_page_available,
	output logic                            local_page_request,
	output logic [agt_pkg::PAGE_W-1:0]      local_page_word_in,
	output logic                            partner_page_read_ack
);
	int sent = 0;
	int wait_n = 0;
	int lag = 0;
	logic [agt_pkg::PAGE_W-1:0] word;

	assign word = 48'h5A00_0000_0000 + 48'(sent);
	assign local_page_request = sent < PAGES;
	// Stale word is inverted once no page is offered
	assign local_page_word_in = local_page_request ? word : ~word;

	always @(posedge clk)
	begin
		if (reset)
		begin
			sent <= 0;
			partner_page_read_ack <= 1'b0;
		end
		else
		begin
			if (local_page_taken_pulse)
				sent <= sent + 1;
			// Ack only while a page is presented, with a varying delay
			if (partner_page_read_ack)
				partner_page_read_ack <= 1'b0;
			else if (partner_page_available && !stall)
			begin
				if (wait_n >= lag)
				begin
					partner_page_read_ack <= 1'b1;
					wait_n <= 0;
					lag <= (lag + 1) % 4;
				end
				else
					wait_n <= wait_n + 1;
			end
		end
	end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench of the negotiation status block
`timescale 1ns/1ns
module testbench;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, stall = 0;
	logic rx_base_page_valid = 0, rx_ext_page_valid = 0, rx_next_page_valid = 0, tx_page_slot = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [47:0] rx_base_page_word = '0, rx_ext_page_word = '0, rx_next_page_word = '0, w, bw, ew;
	logic [3:0] lane_frame_marker = '0, lane_frame_sync = '0, lane_local_ready = '0;
	logic [3:0] lane_partner_ready = '0, lane_ctrl_valid = '0, ep, ei;
	logic [23:0] lane_ctrl_word = '0;
	logic pready, pslverr, local_page_request, partner_page_read_ack, partner_rsfec_request;
	logic partner_kr_fec_request, partner_negotiation_capable, partner_abilities_valid;
	logic local_page_taken_pulse, tx_page_load, partner_page_available, partner_adv_25g_kr1;
	logic partner_adv_25g_cr1, partner_adv_50g_kr2, partner_adv_50g_cr2, rsfec_use_enable;
	logic partner_ext_caps_valid, last_err, ev, ctl4, noise = 0, idle = 1, trn = 0;
	logic [47:0] local_page_word_in, tx_page_word, partner_page_word_out;
	logic [3:0] partner_ext_fec_caps, lane_training_done, lane_training_active, partner_init_bit;
	logic [3:0] lane_training_timeout, lane_train_frame_start, lane_train_frame_locked;
	logic [3:0] partner_preset_bit, ek, fs, fl;
	logic [1:0] lane0_post_tap_update, lane0_main_tap_update;
	int seed = 15, num_errors = 0, checked = 0, cycles = 0, ntaken = 0;
	logic [47:0] np_q[$];

	agt_status #(.LT_TIMEOUT_CYC(20)) dut_u (.*);
	agt_host_model #(.PAGES(5)) host_u (.*);

	always #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checked=%0d num_errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		checked++;
		if (g !== e)
		begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			num_errors++;
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic page(input int kind, input logic [47:0] d);
		@(posedge clk);
		if (kind == 0) begin rx_base_page_word <= d; rx_base_page_valid <= 1; end
		else if (kind == 1) begin rx_ext_page_word <= d; rx_ext_page_valid <= 1; end
		else begin rx_next_page_word <= d; rx_next_page_valid <= 1; end
		@(posedge clk);
		rx_base_page_valid <= 0;
		rx_ext_page_valid <= 0;
		rx_next_page_valid <= 0;
		@(posedge clk);
	endtask

	task automatic wait_low();
		repeat (8)
			if (partner_page_available !== 1'b0)
				@(posedge clk);
		chk(partner_page_available, 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Lane noise, control-bit model and local page monitor
	always @(posedge clk)
	begin
		{fs, fl} = {lane_frame_marker, lane_frame_sync};
		if (reset) begin ep = 0; ei = 0; ek = 0; end
		for (int i = 0; i < 4; i++)
			if (lane_ctrl_valid[i] && !reset)
				{ep[i], ei[i]} = lane_ctrl_word[6*i+4 +: 2];
		if (lane_ctrl_valid[0] && !reset)
			ek = lane_ctrl_word[3:0];
		if (!reset && local_page_taken_pulse === 1'b1)
		begin
			chk(tx_page_word, 48'h5A00_0000_0000 + 48'(ntaken));
			chk(tx_page_load, 1);
			ntaken++;
		end
		if (noise)
		begin
			lane_frame_marker <= 4'($random(seed));
			lane_frame_sync <= 4'($random(seed));
			lane_ctrl_valid <= 4'($random(seed));
			lane_ctrl_word <= 24'($random(seed));
		end
		cycles++;
		if (cycles > 5000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	always @(negedge clk)
		if (!reset)
		begin
			chk(partner_preset_bit, ep);
			chk(partner_init_bit, ei);
			chk({lane0_post_tap_update, lane0_main_tap_update}, ek);
			if (idle | trn)
				chk({lane_train_frame_start, lane_train_frame_locked}, trn ? {fs, fl} : 0);
		end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_an();
		chk(partner_rsfec_request, bw[agt_pkg::BP_RSFEC_REQ]);
		chk(partner_kr_fec_request, bw[agt_pkg::BP_KRFEC_REQ]);
		chk({partner_negotiation_capable, partner_abilities_valid}, 2'b11);
		chk({partner_adv_50g_cr2, partner_adv_50g_kr2, partner_adv_25g_cr1, partner_adv_25g_kr1},
			ew[agt_pkg::EP_25G_KR1 +: 4]);
		chk(partner_ext_fec_caps, ew[agt_pkg::EP_FEC_LSB +: 4]);
		chk(partner_ext_caps_valid, ev);
		chk(rsfec_use_enable, ctl4 & (bw[agt_pkg::BP_RSFEC_REQ]
			| ev & ew[agt_pkg::EP_FEC_LSB + agt_pkg::FEC_CAP_RS]));
	endtask

	initial
	begin
		{ev, bw, ew} = '0;
		repeat (16) @(posedge clk);
		reset <= 0;
		apb(0, agt_pkg::REG_CTRL, 0);
		chk(r, agt_pkg::CTRL_RST);
		apb(0, 8'h40, 0);
		chk({last_err, r}, {1'b1, 32'h0000_0000});
		apb(1, agt_pkg::REG_CTRL, 32'h0000_0010);
		ctl4 = 1;
		for (int k = 0; k < 8; k++)
		begin
			w = 48'({$random(seed), $random(seed)});
			if (k == 4) begin ctl4 = 0; apb(1, agt_pkg::REG_CTRL, 0); end
			if (k % 3 == 2) begin ew = w; ev = 1; page(1, w); end
			else begin bw = w; page(0, w); end
			chk_an();
		end
		apb(0, agt_pkg::REG_AN_STAT, 0);
		chk(r[15:0], {ew[19:16], ew[27:24], 1'b1, bw[45:44], 5'h03});
		apb(1, agt_pkg::REG_CTRL, 32'h0000_0020);
		apb(0, agt_pkg::REG_CTRL, 0);
		chk(r, 0);
		chk({partner_abilities_valid, partner_ext_caps_valid}, 0);
		chk(partner_rsfec_request, bw[agt_pkg::BP_RSFEC_REQ]);
		for (int k = 0; k < 4; k++)
		begin
			np_q.push_back(48'({$random(seed), $random(seed)}));
			page(2, np_q[0]);
			chk(partner_page_available, 1);
			chk(partner_page_word_out, np_q.pop_front());
			wait_low();
		end
		stall <= 1;
		page(2, 48'h0000_1111_2222);
		page(2, 48'h0A0B_3333_4444);
		chk(partner_page_word_out, 48'h0A0B_3333_4444);
		apb(0, agt_pkg::REG_NP_HI, 0);
		chk(r, 32'h0000_0A0B);
		apb(0, agt_pkg::REG_NP_LO, 0);
		chk(r, 32'h3333_4444);
		apb(0, agt_pkg::REG_AN_STAT, 0);
		chk(r[3:2], 2'b11);
		apb(1, agt_pkg::REG_AN_STAT, 32'h0000_0008);
		apb(0, agt_pkg::REG_AN_STAT, 0);
		chk(r[3], 0);
		stall <= 0;
		wait_low();
		repeat (8)
		begin
			@(posedge clk);
			tx_page_slot <= 1;
			@(posedge clk);
			tx_page_slot <= 0;
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
		chk(ntaken, 5);
		noise <= 1;
		repeat (30) @(posedge clk);
		idle = 0;
		apb(1, agt_pkg::REG_CTRL, 32'h0000_000F);
		repeat (5) @(posedge clk);
		chk({lane_training_active, lane_training_done}, 8'hF0);
		trn = 1;
		lane_local_ready <= 4'b0011;
		lane_partner_ready <= 4'b1011;
		repeat (4) @(posedge clk);
		chk(lane_training_done, 4'b0011);
		repeat (25) @(posedge clk);
		chk(lane_training_timeout, 4'b1100);
		apb(0, agt_pkg::REG_LT_STAT, 0);
		chk(r & 32'h0000_0F0F, 32'h0000_0C03);
		trn = 0;
		apb(1, agt_pkg::REG_CTRL, 0);
		repeat (3) @(posedge clk);
		idle = 1;
		chk({lane_training_done, lane_training_timeout}, 0);
		repeat (20) @(posedge clk);
		print_verdict();
	end
endmodule
